// ===== smsp_pkg.sv
// constants, types and helpers for the serial master/slave port
// Operation
// - host data moves in blocks of at most 200 words, count rounded up
// - zero failure setting keeps serial traffic running despite backplane faults
// - positive setting N halts serial traffic after N consecutive backplane failures
// - one good backplane transfer resumes halted serial traffic
// - status pointer of -1 stores nothing, 0 to 4939 selects the location
// - each port holds a local station number from 0 to 254
// - parity code 0 none, 1 odd, 2 even, 3 mark, 4 space
// - bit rate selectable from 110 to 115200 baud
// - wait at least the minimum reply delay before answering a request
// - after raising request-to-send wait the pre-transmit delay before data
// - after the last data wait the post-transmit delay before dropping it
// - clear-to-send honoured when option is 1, ignored when 0
// - half duplex waits the enquiry delay after an ack before sending
// - master leaves at least the command gap between successive commands, except that a retry is reissued at once without it
// - master fails a command when no reply comes within the timeout
// - master reissues a failed request up to the retry count
// - after a command error skip that command for the configured list cycles
// - station list refreshed every N list cycles, zero disables it
// - enable 0 skips, 1 runs each scan by interval, 2 sends on change
// - continuous command not reissued before its issue interval in seconds
// - each command moves 1 to 100 registers from its start address
// - read data swap: 0 none, 1 words, 2 words and bytes, 3 bytes
package smsp_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned MS_PER_SEC = 1000;
	localparam int unsigned MS_TIME = 1;
	localparam logic [15:0] BLOCK_WORDS = 16'h00c8;
	localparam logic [15:0] STORE_OFF = 16'hffff;
	localparam logic [15:0] STORE_MAX = 16'h134b;
	localparam logic [7:0] STATION_MAX = 8'hfe;
	localparam logic [6:0] CNT_MIN = 7'h01;
	localparam logic [6:0] CNT_MAX = 7'h64;
	localparam int CMD_DEPTH = 16;
	localparam int CMD_AW = 4;
	localparam logic [3:0] BITS_MIN = 4'h5;
	localparam logic [3:0] BITS_MAX = 4'h8;
	typedef enum logic [2:0] {
		PAR_NONE = 3'b000, PAR_ODD = 3'b001, PAR_EVEN = 3'b010,
		PAR_MARK = 3'b011, PAR_SPACE = 3'b100
	} smsp_par_t;
	typedef enum logic [1:0] {
		EN_OFF = 2'b00, EN_CONT = 2'b01, EN_CHANGE = 2'b10
	} smsp_en_t;
	typedef enum logic [1:0] {
		SW_NONE = 2'b00, SW_WORD = 2'b01, SW_BOTH = 2'b10, SW_BYTE = 2'b11
	} smsp_swap_t;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_RTS_ON = 3'b001, T_CTS = 3'b010, T_START = 3'b011,
		T_DATA = 3'b100, T_PAR = 3'b101, T_STOP = 3'b110, T_RTS_OFF = 3'b111
	} smsp_tx_t;
	typedef enum logic [2:0] {
		M_GAP = 3'b000, M_PICK = 3'b001, M_ISSUE = 3'b010, M_WAIT = 3'b011,
		M_NEXT = 3'b100
	} smsp_mst_t;
	typedef struct packed {
		logic [1:0] enable;
		logic [12:0] start_addr;
		logic [15:0] interval;
		logic [6:0] count;
		logic [1:0] swap;
		logic [7:0] node;
	} smsp_cmd_t;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} smsp_txw_t;
	typedef struct packed {
		logic master;
		logic half_duplex;
		logic [7:0] station;
		logic [3:0] baud_sel;
		logic [2:0] parity;
		logic [3:0] data_bits;
		logic two_stop;
		logic cts_honour;
		logic [15:0] min_reply;
		logic [15:0] pre_tx;
		logic [15:0] post_tx;
		logic [15:0] enquiry;
	} smsp_port_cfg_t;
	typedef struct packed {
		logic [CMD_AW:0] list_length;
		logic [15:0] gap;
		logic [15:0] timeout;
		logic [7:0] retries;
		logic [15:0] skip_cycles;
		logic [15:0] refresh;
	} smsp_mst_cfg_t;
	// bit period in clocks for each rate code, 110 up to 115200
	function automatic logic [16:0] smsp_baud_div(input logic [3:0] sel);
		case (sel)
			4'h0: smsp_baud_div = 17'(CLK_HZ / 110);
			4'h1: smsp_baud_div = 17'(CLK_HZ / 300);
			4'h2: smsp_baud_div = 17'(CLK_HZ / 600);
			4'h3: smsp_baud_div = 17'(CLK_HZ / 1200);
			4'h4: smsp_baud_div = 17'(CLK_HZ / 2400);
			4'h5: smsp_baud_div = 17'(CLK_HZ / 4800);
			4'h6: smsp_baud_div = 17'(CLK_HZ / 9600);
			4'h7: smsp_baud_div = 17'(CLK_HZ / 19200);
			4'h8: smsp_baud_div = 17'(CLK_HZ / 38400);
			4'h9: smsp_baud_div = 17'(CLK_HZ / 57600);
			default: smsp_baud_div = 17'(CLK_HZ / 115200);
		endcase
	endfunction
endpackage

// ===== smsp_port.sv
// serial master/slave port: paging, backplane policy, framing, master scheduler
`timescale 1ns/100ps
module smsp_port
	import smsp_pkg::*;
#(
	parameter int unsigned MS_CYCLES = (CLK_HZ / 1000) * MS_TIME
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// host block paging
	input wire logic [15:0] register_count,
	output logic [15:0] block_count,
	output logic [7:0] last_block_words,
	// backplane transfer health
	input wire logic bp_xfer_ok,
	input wire logic bp_xfer_fail,
	input wire logic [15:0] backplane_fail_retries,
	output logic comm_halted,
	// status placement
	input wire logic [15:0] status_store_pointer,
	output logic status_store_enable,
	output logic [12:0] status_store_addr,
	// port configuration
	input wire smsp_port_cfg_t port_cfg,
	output logic [7:0] local_station_number,
	// serial line and framing events
	input wire logic cts_in,
	input wire logic rx_frame_end,
	input wire logic ack_received,
	output logic tx_line,
	output logic rts_out,
	// transmit bytes
	input wire logic txw_valid,
	input wire smsp_txw_t txw,
	output logic txw_ready,
	// master configuration and command table
	input wire smsp_mst_cfg_t mst_cfg,
	input wire logic cmd_wr,
	input wire logic [CMD_AW-1:0] cmd_wr_idx,
	input wire smsp_cmd_t cmd_wr_data,
	input wire logic [CMD_DEPTH-1:0] cmd_data_changed,
	input wire logic reply_received,
	output logic cmd_issue,
	output logic [CMD_AW-1:0] cmd_issue_idx,
	output smsp_cmd_t cmd_out,
	output logic cmd_failed,
	output logic cmd_error,
	output logic station_list_update,
	// read data reordering
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	output logic rd_out_valid,
	output logic [31:0] rd_out
);
	////////////////////////////////////////////////////////////////
	// time base: millisecond and second enables
	logic [13:0] ms_cnt_reg;
	logic [9:0] sec_cnt_reg;
	wire ms_tick = (ms_cnt_reg == 14'(MS_CYCLES - 1));
	wire sec_tick = ms_tick && (sec_cnt_reg == 10'(MS_PER_SEC - 1));
	always_ff @(posedge sys_clk) begin
		if (reset || ms_tick) ms_cnt_reg <= '0;
		else ms_cnt_reg <= ms_cnt_reg + 14'h0001;
		if (reset || sec_tick) sec_cnt_reg <= '0;
		else if (ms_tick) sec_cnt_reg <= sec_cnt_reg + 10'h001;
	end

	////////////////////////////////////////////////////////////////
	// paging, status placement and station number
	wire [15:0] blocks_next = 16'((32'(register_count) + 32'(BLOCK_WORDS) - 1) / 32'(BLOCK_WORDS));
	wire [15:0] rem_words = 16'(register_count % BLOCK_WORDS);
	wire [7:0] last_next = (rem_words == 16'h0000 && register_count != 16'h0000) ?
		8'(BLOCK_WORDS) : 8'(rem_words);
	wire store_ok = (status_store_pointer != STORE_OFF) && (status_store_pointer <= STORE_MAX);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			block_count <= '0;
			last_block_words <= '0;
			status_store_enable <= 1'b0;
			status_store_addr <= '0;
			local_station_number <= '0;
		end else begin
			block_count <= blocks_next;
			last_block_words <= last_next;
			status_store_enable <= store_ok;
			status_store_addr <= status_store_pointer[12:0];
			if (port_cfg.station <= STATION_MAX) local_station_number <= port_cfg.station;
		end
	end

	////////////////////////////////////////////////////////////////
	// backplane failure policy
	logic [15:0] bp_fail_cnt_reg;
	wire [15:0] bp_fail_inc = bp_fail_cnt_reg + 16'h0001;
	wire bp_limit = (backplane_fail_retries != 16'h0000) && (bp_fail_inc >= backplane_fail_retries);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bp_fail_cnt_reg <= '0;
			comm_halted <= 1'b0;
		end else if (bp_xfer_ok) begin
			bp_fail_cnt_reg <= '0;
			comm_halted <= 1'b0;
		end else if (bp_xfer_fail) begin
			if (bp_fail_inc != 16'h0000) bp_fail_cnt_reg <= bp_fail_inc;
			if (bp_limit) comm_halted <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// two-entry transmit buffer
	smsp_txw_t buf_mem [2];
	logic buf_wp_reg;
	logic buf_rp_reg;
	logic [1:0] buf_cnt_reg;
	logic buf_pop;
	wire buf_push = txw_valid && txw_ready;
	wire buf_valid = (buf_cnt_reg != 2'b00);
	wire [1:0] buf_cnt_next = 2'(buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop});
	smsp_txw_t buf_head;
	assign buf_head = buf_mem[buf_rp_reg];
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_cnt_reg <= '0;
			txw_ready <= 1'b0;
		end else begin
			if (buf_push) buf_wp_reg <= ~buf_wp_reg;
			if (buf_pop) buf_rp_reg <= ~buf_rp_reg;
			buf_cnt_reg <= buf_cnt_next;
			txw_ready <= (buf_cnt_next != 2'b10);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (buf_push) buf_mem[buf_wp_reg] <= txw;
	end

	////////////////////////////////////////////////////////////////
	// reply hold-off: minimum reply delay and enquiry delay
	logic [15:0] hold_reg;
	always_ff @(posedge sys_clk) begin
		if (reset) hold_reg <= '0;
		else if (rx_frame_end && !port_cfg.master) hold_reg <= port_cfg.min_reply;
		else if (ack_received && port_cfg.half_duplex) hold_reg <= port_cfg.enquiry;
		else if (ms_tick && hold_reg != 16'h0000) hold_reg <= hold_reg - 16'h0001;
	end

	////////////////////////////////////////////////////////////////
	// transmitter: request-to-send sequencing and character framing
	smsp_tx_t tx_state_reg;
	smsp_tx_t tx_state_next;
	logic [16:0] baud_cnt_reg;
	logic [15:0] dly_reg;
	logic [2:0] bit_idx_reg;
	logic stop_idx_reg;
	logic [7:0] shift_reg;
	logic par_acc_reg;
	logic last_reg;
	wire [16:0] bit_div = smsp_baud_div(port_cfg.baud_sel);
	wire baud_end = (baud_cnt_reg == bit_div - 17'h00001);
	wire dly_done = (dly_reg == 16'h0000);
	wire cts_ok = !port_cfg.cts_honour || cts_in;
	wire [3:0] nbits = (port_cfg.data_bits < BITS_MIN) ? BITS_MIN :
		(port_cfg.data_bits > BITS_MAX) ? BITS_MAX : port_cfg.data_bits;
	wire data_end = ({1'b0, bit_idx_reg} == nbits - 4'h1);
	wire has_par = (port_cfg.parity != PAR_NONE);
	wire par_now = (tx_state_reg == T_DATA) ? par_acc_reg ^ shift_reg[0] : par_acc_reg;
	// parity bit value for the selected mode, last data bit folded in
	logic par_bit;
	always_comb begin
		case (smsp_par_t'(port_cfg.parity))
			PAR_ODD: par_bit = ~par_now;
			PAR_EVEN: par_bit = par_now;
			PAR_MARK: par_bit = 1'b1;
			PAR_SPACE: par_bit = 1'b0;
			default: par_bit = 1'b0;
		endcase
	end
	// next state of the transmitter
	always_comb begin
		tx_state_next = tx_state_reg;
		buf_pop = 1'b0;
		case (tx_state_reg)
			T_IDLE: if (buf_valid && !comm_halted && hold_reg == 16'h0000)
				tx_state_next = T_RTS_ON;
			T_RTS_ON: if (dly_done) tx_state_next = T_CTS;
			T_CTS: if (cts_ok) begin
				tx_state_next = T_START;
				buf_pop = 1'b1;
			end
			T_START: if (baud_end) tx_state_next = T_DATA;
			T_DATA: if (baud_end && data_end) tx_state_next = has_par ? T_PAR : T_STOP;
			T_PAR: if (baud_end) tx_state_next = T_STOP;
			T_STOP: if (baud_end && (stop_idx_reg || !port_cfg.two_stop)) begin
				if (!last_reg && buf_valid && cts_ok) begin
					tx_state_next = T_START;
					buf_pop = 1'b1;
				end else if (!last_reg) tx_state_next = T_CTS;
				else tx_state_next = T_RTS_OFF;
			end
			T_RTS_OFF: if (dly_done) tx_state_next = T_IDLE;
			default: tx_state_next = T_IDLE;
		endcase
	end
	// transmitter registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_state_reg <= T_IDLE;
			baud_cnt_reg <= '0;
			dly_reg <= '0;
			bit_idx_reg <= '0;
			stop_idx_reg <= 1'b0;
			shift_reg <= '0;
			par_acc_reg <= 1'b0;
			last_reg <= 1'b0;
			tx_line <= 1'b1;
			rts_out <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			baud_cnt_reg <= (baud_end || tx_state_next != tx_state_reg) ? '0 :
				baud_cnt_reg + 17'h00001;
			if (tx_state_reg == T_IDLE) dly_reg <= port_cfg.pre_tx;
			else if (tx_state_next == T_RTS_OFF && tx_state_reg != T_RTS_OFF)
				dly_reg <= port_cfg.post_tx;
			else if (ms_tick && !dly_done) dly_reg <= dly_reg - 16'h0001;
			if (buf_pop) begin
				shift_reg <= buf_head.data;
				last_reg <= buf_head.last;
				par_acc_reg <= 1'b0;
				bit_idx_reg <= '0;
				stop_idx_reg <= 1'b0;
			end else if (baud_end && tx_state_reg == T_DATA) begin
				par_acc_reg <= par_acc_reg ^ shift_reg[0];
				shift_reg <= {1'b0, shift_reg[7:1]};
				bit_idx_reg <= bit_idx_reg + 3'h1;
			end else if (baud_end && tx_state_reg == T_STOP) stop_idx_reg <= 1'b1;
			rts_out <= (tx_state_next != T_IDLE);
			case (tx_state_next)
				T_START: tx_line <= 1'b0;
				T_DATA: tx_line <= (tx_state_reg == T_DATA && baud_end) ? shift_reg[1] :
					shift_reg[0];
				T_PAR: tx_line <= par_bit;
				default: tx_line <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// master command table and per-command timers
	smsp_cmd_t cmd_mem [CMD_DEPTH];
	logic [15:0] age_reg [CMD_DEPTH];
	logic [15:0] skip_reg [CMD_DEPTH];
	smsp_mst_t m_state_reg;
	logic [CMD_AW-1:0] m_idx_reg;
	logic [15:0] m_tmr_reg;
	logic [7:0] m_try_reg;
	logic [15:0] m_cycle_reg;
	smsp_cmd_t cur;
	assign cur = cmd_mem[m_idx_reg];
	wire cnt_ok = (cur.count >= CNT_MIN) && (cur.count <= CNT_MAX);
	wire due_cont = (cur.enable == EN_CONT) && (age_reg[m_idx_reg] >= cur.interval);
	wire due_chg = (cur.enable == EN_CHANGE) && cmd_data_changed[m_idx_reg];
	wire skipping = (skip_reg[m_idx_reg] != 16'h0000);
	wire cmd_due = cnt_ok && !skipping && (due_cont || due_chg);
	wire list_wrap = ({1'b0, m_idx_reg} + 5'h01 >= mst_cfg.list_length);
	wire m_timeout = (m_tmr_reg == 16'h0000) && !reply_received;
	wire m_error = m_timeout && (m_try_reg >= mst_cfg.retries);
	wire m_run = port_cfg.master && !comm_halted && (mst_cfg.list_length != '0);
	always_ff @(posedge sys_clk) begin
		if (cmd_wr) cmd_mem[cmd_wr_idx] <= cmd_wr_data;
	end
	// issue age in seconds and error skip count for each entry
	genvar gi;
	generate
		for (gi = 0; gi < CMD_DEPTH; gi++) begin : g_cmd
			wire sel = (m_idx_reg == CMD_AW'(gi));
			always_ff @(posedge sys_clk) begin
				if (reset) age_reg[gi] <= 16'hffff;
				else if (cmd_issue && sel) age_reg[gi] <= '0;
				else if (sec_tick && age_reg[gi] != 16'hffff) age_reg[gi] <= age_reg[gi] + 16'h0001;
				if (reset || (cmd_wr && cmd_wr_idx == CMD_AW'(gi))) skip_reg[gi] <= '0;
				else if (sel && m_state_reg == M_WAIT && m_error)
					skip_reg[gi] <= mst_cfg.skip_cycles;
				else if (sel && m_state_reg == M_PICK && skip_reg[gi] != 16'h0000)
					skip_reg[gi] <= skip_reg[gi] - 16'h0001;
			end
		end
	endgenerate
	// master scheduler
	always_ff @(posedge sys_clk) begin
		if (reset || !m_run) begin
			m_state_reg <= M_GAP;
			m_idx_reg <= '0;
			m_tmr_reg <= mst_cfg.gap;
			m_try_reg <= '0;
			cmd_issue <= 1'b0;
			cmd_failed <= 1'b0;
			cmd_error <= 1'b0;
			if (reset) begin
				m_cycle_reg <= '0;
				station_list_update <= 1'b0;
				cmd_issue_idx <= '0;
				cmd_out <= '0;
			end
		end else begin
			cmd_issue <= 1'b0;
			cmd_failed <= 1'b0;
			cmd_error <= 1'b0;
			station_list_update <= 1'b0;
			case (m_state_reg)
				M_GAP: if (m_tmr_reg == 16'h0000) m_state_reg <= M_PICK;
					else if (ms_tick) m_tmr_reg <= m_tmr_reg - 16'h0001;
				M_PICK: begin
					m_try_reg <= '0;
					m_state_reg <= cmd_due ? M_ISSUE : M_NEXT;
				end
				M_ISSUE: begin
					cmd_issue <= 1'b1;
					cmd_issue_idx <= m_idx_reg;
					cmd_out <= cur;
					m_tmr_reg <= mst_cfg.timeout;
					m_state_reg <= M_WAIT;
				end
				M_WAIT: if (reply_received) begin
					m_tmr_reg <= mst_cfg.gap;
					m_state_reg <= M_NEXT;
				end else if (m_timeout) begin
					cmd_failed <= 1'b1;
					m_tmr_reg <= mst_cfg.gap;
					if (m_error) begin
						cmd_error <= 1'b1;
						m_state_reg <= M_NEXT;
					end else begin
						m_try_reg <= m_try_reg + 8'h01;
						m_state_reg <= M_ISSUE;
					end
				end else if (ms_tick) m_tmr_reg <= m_tmr_reg - 16'h0001;
				M_NEXT: begin
					m_state_reg <= M_GAP;
					if (list_wrap) begin
						m_idx_reg <= '0;
						if (mst_cfg.refresh != 16'h0000 && m_cycle_reg + 16'h0001 >= mst_cfg.refresh) begin
							m_cycle_reg <= '0;
							station_list_update <= 1'b1;
						end else m_cycle_reg <= m_cycle_reg + 16'h0001;
					end else m_idx_reg <= m_idx_reg + CMD_AW'(1);
				end
				default: m_state_reg <= M_GAP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// read data reordering by the issued command's swap code
	logic [31:0] swapped;
	always_comb begin
		case (smsp_swap_t'(cmd_out.swap))
			SW_WORD: swapped = {rd_data[15:0], rd_data[31:16]};
			SW_BOTH: swapped = {rd_data[7:0], rd_data[15:8], rd_data[23:16], rd_data[31:24]};
			SW_BYTE: swapped = {rd_data[23:16], rd_data[31:24], rd_data[7:0], rd_data[15:8]};
			default: swapped = rd_data;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_out_valid <= 1'b0;
			rd_out <= '0;
		end else begin
			rd_out_valid <= rd_valid;
			if (rd_valid) rd_out <= swapped;
		end
	end
endmodule // smsp_port

// ===== smsp_station_model.sv
// far-side station model that answers master commands
`timescale 1ns/100ps
module smsp_station_model (
	// clock and reset
	input logic sys_clk,
	input logic reset,
	// command seen and reply given
	input logic cmd_issue,
	input logic [3:0] reply_delay,
	output logic reply_received
);
	logic [3:0] wait_reg;
	// reply reply_delay cycles after a command, zero is silent
	always_ff @(posedge sys_clk) begin
		if (reset) wait_reg <= 4'h0;
		else if (cmd_issue) wait_reg <= reply_delay;
		else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
		reply_received <= !reset && !cmd_issue && wait_reg == 4'h1;
	end
endmodule // smsp_station_model

// ===== smsp_port_asserts.sv
// concurrent checks on the serial master/slave port
`timescale 1ns/100ps
module smsp_port_asserts
	import smsp_pkg::*;
(
	// clock and reset
	input logic sys_clk,
	input logic reset,
	// paging and status placement
	input logic [15:0] register_count,
	input logic [15:0] block_count,
	input logic [7:0] last_block_words,
	input logic [15:0] status_store_pointer,
	input logic status_store_enable,
	// backplane health
	input logic bp_xfer_ok,
	input logic bp_xfer_fail,
	input logic [15:0] backplane_fail_retries,
	input logic comm_halted,
	// line and master
	input logic tx_line,
	input logic rts_out,
	input logic cmd_issue,
	input smsp_cmd_t cmd_out,
	// read data
	input logic rd_valid,
	input logic [31:0] rd_data,
	input logic rd_out_valid,
	input logic [31:0] rd_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [15:0] fail_run;
	// failures since the last good transfer
	always_ff @(posedge sys_clk) begin
		if (reset || bp_xfer_ok)
			fail_run <= 16'h0000;
		else if (bp_xfer_fail && fail_run != 16'hffff)
			fail_run <= fail_run + 16'h0001;
	end
	// reorder a read word by swap code
	function automatic logic [31:0] swap32(input logic [1:0] s, input logic [31:0] d);
		if (s[0] ^ s[1]) d = {d[15:0], d[31:16]};
		if (s[1]) d = {d[23:16], d[31:24], d[7:0], d[15:8]};
		swap32 = d;
	endfunction
	sequence s_quiet;
		!cmd_issue [*3];
	endsequence
	sequence s_lead;
		tx_line [*2];
	endsequence
	////////////////////////////////////////////////////////////////
	a_block_count: assert property (
		!$past(reset) |-> block_count == 16'(({1'b0, $past(register_count)} + 17'hc7) / 17'hc8))
		else $error("bad block count");
	a_last_words: assert property (
		!$past(reset) |-> last_block_words == 8'(($past(register_count) == 16'h0) ? 16'h0
		: ($past(register_count) - 16'h1) % BLOCK_WORDS + 16'h1))
		else $error("bad last block");
	a_store_gate: assert property (
		!$past(reset) |-> status_store_enable == ($past(status_store_pointer) != STORE_OFF
		&& $past(status_store_pointer) <= STORE_MAX))
		else $error("bad store gate");
	a_halt_count: assert property (
		bp_xfer_fail && !bp_xfer_ok && backplane_fail_retries != 16'h0
		&& fail_run >= backplane_fail_retries - 16'h1 |=> comm_halted)
		else $error("no halt");
	a_zero_runs: assert property (
		$past(backplane_fail_retries) == 16'h0 && !$past(comm_halted) |-> !comm_halted)
		else $error("halt at zero");
	a_resume_ok: assert property (bp_xfer_ok |=> !comm_halted)
		else $error("no resume");
	a_halt_quiet: assert property (
		$past(comm_halted, 2) && $past(comm_halted) && comm_halted |-> !cmd_issue)
		else $error("issue while halted");
	a_rd_swap: assert property (
		rd_valid |=> rd_out_valid && rd_out == swap32($past(cmd_out.swap), $past(rd_data)))
		else $error("bad swap");
	a_issue_legal: assert property (
		cmd_issue |-> cmd_out.enable != EN_OFF && cmd_out.count >= CNT_MIN && cmd_out.count <= CNT_MAX)
		else $error("bad issue");
	a_issue_gap: assert property (cmd_issue |=> s_quiet)
		else $error("gap short");
	a_rts_lead: assert property ($rose(rts_out) |-> s_lead)
		else $error("no lead");
	a_tx_in_rts: assert property (!tx_line |-> rts_out)
		else $error("line without rts");
endmodule // smsp_port_asserts
bind smsp_port smsp_port_asserts u_smsp_port_asserts (.sys_clk, .reset, .register_count,
	.block_count, .last_block_words, .status_store_pointer, .status_store_enable, .bp_xfer_ok,
	.bp_xfer_fail, .backplane_fail_retries, .comm_halted, .tx_line, .rts_out, .cmd_issue,
	.cmd_out, .rd_valid, .rd_data, .rd_out_valid, .rd_out);

// ===== serial_master_slave_port_config_bench.sv
// self-checking bench for the serial master/slave port
`timescale 1ns/100ps
module serial_master_slave_port_config_bench
	import smsp_pkg::*;
();
	localparam int BITC = CLK_HZ / 115200;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] register_count, block_count, backplane_fail_retries, status_store_pointer;
	logic [7:0] last_block_words, local_station_number;
	logic bp_xfer_ok, bp_xfer_fail, comm_halted, status_store_enable, cts_in, tx_line, rts_out;
	logic txw_valid, txw_ready, cmd_wr, reply_received, cmd_issue, cmd_failed, cmd_error;
	logic station_list_update;
	logic rd_valid, rd_out_valid;
	logic [12:0] status_store_addr;
	logic [3:0] cmd_wr_idx, cmd_issue_idx, reply_delay;
	logic [31:0] rd_data, rd_out, rnd, rd_q[$], tx_q[$], iss_q[$];
	logic [15:0] cnts[8] = '{16'h0, 16'h1, 16'hc7, 16'hc8, 16'hc9, 16'h1c2, 16'h258, 16'h0};
	logic [15:0] ptrs[8] = '{16'hffff, 16'h0, 16'h134b, 16'h134c, 16'h1234, 16'h8000, 16'h1, 16'hfffe};
	logic [35:0] bps = 36'h4928946d2;
	smsp_port_cfg_t pc;
	smsp_mst_cfg_t mc;
	smsp_cmd_t cmd_wr_data, cmd_out;
	smsp_txw_t txw;
	int n_mismatch, n_tests, n_iss, n_fail, n_err, tmo, t_iss, n;
	smsp_port #(.MS_CYCLES(10)) u_smsp_port (.sys_clk, .reset, .register_count, .block_count,
		.last_block_words, .bp_xfer_ok, .bp_xfer_fail, .backplane_fail_retries, .comm_halted,
		.status_store_pointer, .status_store_enable, .status_store_addr, .port_cfg(pc),
		.local_station_number, .cts_in, .rx_frame_end(1'b0), .ack_received(1'b0), .tx_line,
		.rts_out, .txw_valid, .txw, .txw_ready, .mst_cfg(mc), .cmd_wr, .cmd_wr_idx, .cmd_wr_data,
		.cmd_data_changed(16'h0000), .reply_received, .cmd_issue, .cmd_issue_idx, .cmd_out,
		.cmd_failed, .cmd_error, .station_list_update, .rd_valid, .rd_data, .rd_out_valid, .rd_out);
	smsp_station_model u_smsp_station_model (.sys_clk, .reset, .cmd_issue, .reply_delay,
		.reply_received);
	// 100 ns clock
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] swap32(input logic [1:0] s, input logic [31:0] d);
		if (s[0] ^ s[1]) d = {d[15:0], d[31:16]};
		if (s[1]) d = {d[23:16], d[31:24], d[7:0], d[15:8]};
		swap32 = d;
	endfunction
	// expected stop, parity, data
	function automatic logic [31:0] frame(input logic [7:0] d);
		logic p;
		p = (pc.parity == 3'h1) ? ~^d : (pc.parity == 3'h2) ? ^d : (pc.parity == 3'h3);
		frame = {22'h0, 1'b1, p, d};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr_cmd(input int i, input smsp_cmd_t c);
		cmd_wr = 1'b1;
		cmd_wr_idx = 4'(i);
		cmd_wr_data = c;
		@(negedge sys_clk);
		cmd_wr = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic wait_idle;
		while (tx_q.size() != 0 || rts_out !== 1'b0)
			@(negedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////
	// compare results with the oldest note, then the hang guard
	always @(posedge sys_clk) begin
		tmo++;
		if (rd_out_valid === 1'b1)
			check(rd_out, rd_q.pop_front());
		if (cmd_issue === 1'b1) begin
			n_iss++;
			t_iss = tmo;
			if (iss_q.size() > 0)
				check(cmd_issue_idx, iss_q.pop_front());
		end
		if (cmd_failed === 1'b1) begin
			n_fail++;
			check(tmo - t_iss >= 10 && tmo - t_iss <= 32, 1);
		end
		if (cmd_error === 1'b1)
			n_err++;
		if (station_list_update === 1'b1)
			check(cmd_issue_idx, (mc.list_length == 5'h05) ? 4'h3 : 4'h0);
		if (tmo == 40000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// decode line frames
	initial begin
		logic [7:0] b;
		logic p;
		forever begin
			@(negedge tx_line);
			repeat (BITC / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BITC) @(posedge sys_clk);
				b[i] = tx_line;
			end
			p = 1'b0;
			if (pc.parity != 3'h0) begin
				repeat (BITC) @(posedge sys_clk);
				p = tx_line;
			end
			repeat (BITC) @(posedge sys_clk);
			check({tx_line, p, b}, tx_q.pop_front());
		end
	end
	// main sequence
	initial begin
		{register_count, backplane_fail_retries, status_store_pointer, rd_data} = '0;
		{bp_xfer_ok, bp_xfer_fail, cts_in, txw_valid, cmd_wr, rd_valid} = '0;
		{pc, mc, txw, cmd_wr_data, cmd_wr_idx, reply_delay} = '0;
		rnd = 32'h0001_6826;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		// paging, status, station
		foreach (cnts[i]) begin
			register_count = (i == 7) ? rnd[15:0] : cnts[i];
			status_store_pointer = ptrs[i];
			pc.station = 8'(i * 36);
			@(negedge sys_clk);
			check(block_count, (register_count + 17'hc7) / 17'hc8);
			check(last_block_words, register_count ? (register_count - 1) % 200 + 1 : 0);
			check(status_store_enable, ptrs[i] != 16'hffff && ptrs[i] <= 16'h134b);
			check(status_store_addr, ptrs[i][12:0]);
			check(local_station_number, pc.station);
		end
		pc.station = 8'hff;
		@(negedge sys_clk);
		check(local_station_number, 8'hfc);
		// backplane: 3 fails halt, ok resumes, 0 never halts
		backplane_fail_retries = 16'h0003;
		for (int i = 0; i < 12; i++) begin
			{bp_xfer_ok, bp_xfer_fail} = bps[3 * i + 1 +: 2];
			@(negedge sys_clk);
			{bp_xfer_ok, bp_xfer_fail} = 2'b00;
			if (i == 9)
				backplane_fail_retries = 16'h0000;
			@(negedge sys_clk);
			check(comm_halted, bps[3 * i]);
		end
		// cts low stalls the line, buffer fills
		pc.baud_sel = 4'ha;
		pc.data_bits = 4'h8;
		pc.cts_honour = 1'b1;
		txw_valid = 1'b1;
		for (int i = 0; i < 5; i++) begin
			txw = '{data: rnd[7:0], last: 1'b1};
			@(posedge sys_clk);
			if (txw_ready === 1'b1) begin
				n++;
				tx_q.push_back(frame(rnd[7:0]));
				rnd = lfsr(rnd);
			end
			@(negedge sys_clk);
		end
		txw_valid = 1'b0;
		check(n, 2);
		repeat (40) @(negedge sys_clk);
		check({rts_out, tx_line}, 2'b11);
		cts_in = 1'b1;
		wait_idle();
		// each parity, cts ignored
		cts_in = 1'b0;
		pc.cts_honour = 1'b0;
		for (int p = 0; p < 5; p++) begin
			pc.parity = 3'(p);
			txw = '{data: rnd[7:0], last: 1'b1};
			tx_q.push_back(frame(rnd[7:0]));
			txw_valid = 1'b1;
			do @(posedge sys_clk); while (txw_ready !== 1'b1);
			@(negedge sys_clk);
			txw_valid = 1'b0;
			rnd = lfsr(rnd);
			wait_idle();
		end
		// master scan, four live entries
		for (int i = 0; i < 5; i++)
			wr_cmd(i, '{(i < 4) ? EN_CONT : EN_OFF, 13'(i), 16'h0, 7'(i + 1), 2'(i), 8'(i)});
		mc = '{5'h05, 16'h0001, 16'h0002, 8'h01, 16'h0002, 16'h0001};
		reply_delay = 4'h3;
		for (int i = 0; i < 8; i++)
			iss_q.push_back(i % 4);
		pc.master = 1'b1;
		for (int i = 0; i < 8; i++) begin
			while (cmd_issue !== 1'b1)
				@(negedge sys_clk);
			rnd = lfsr(rnd);
			rd_data = rnd;
			rd_valid = 1'b1;
			rd_q.push_back(swap32(2'(i), rnd));
			@(negedge sys_clk);
			rd_valid = 1'b0;
		end
		// silent station: retry, then error
		reply_delay = 4'h0;
		repeat (2) @(negedge sys_clk);
		reset = 1'b1;
		mc.list_length = 5'h01;
		@(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		n_iss = 0;
		n_fail = 0;
		n_err = 0;
		wr_cmd(0, '{EN_CONT, 13'h0, 16'h0, 7'h1, 2'h0, 8'h1});
		while (n_err == 0)
			@(negedge sys_clk);
		check(n_fail, 2);
		check(n_iss, 2);
		complete_run();
	end
endmodule // serial_master_slave_port_config_bench
